// >>> common/tcc_pkg.sv
// How it works
// - filter output moves after four equal samples
// - filter adds four cycles of capture delay
// - edge select zero falling, one rising
// - capture copies counter and sets capture flag
// - capture pin ignored when capture is top
// - clock select codes stop, /1, /8../1024
// - codes 110/111 count external falling/rising edges
// - force bits act only in non-PWM modes
// - force applies compare action to output now
// - force sets no flag, clears no counter
// - force bits are strobes, read zero
// - low byte at base, high at base+1
// - shared high-byte holding register for 16-bit access
// - counter write blocks next timer-clock compare match
// - capture source is pin or comparator
// - wave mode sets top; counts up, clears at top in every mode
// - capture flag cleared by vector or one-write
// - compare-A flag set tick after equality
package tcc_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] OFS_CTRL_A = 8'h80;
	localparam logic [7:0] OFS_CTRL_B = 8'h81;
	localparam logic [7:0] OFS_CTRL_C = 8'h82;
	localparam logic [7:0] OFS_COUNT = 8'h84;
	localparam logic [7:0] OFS_CAPTURE = 8'h86;
	localparam logic [7:0] OFS_COMPARE_A = 8'h88;
	localparam logic [7:0] OFS_FLAGS = 8'h8C;
	localparam logic [7:0] OFS_OPTION = 8'h8D;
	localparam logic [7:0] HIGH_BYTE_STEP = 8'h01;

	// ************************************************************
	// field positions and masks
	// ************************************************************
	localparam int unsigned B_NOISE_BIT = 7;
	localparam int unsigned B_EDGE_BIT = 6;
	localparam int unsigned B_WM3_BIT = 4;
	localparam int unsigned B_WM2_BIT = 3;
	localparam int unsigned B_CS_LSB = 0;
	localparam logic [7:0] CTRL_B_MASK = 8'hDF;
	localparam int unsigned A_ACT_A_LSB = 6;
	localparam int unsigned A_ACT_B_LSB = 4;
	localparam int unsigned A_WM_LSB = 0;
	localparam logic [7:0] CTRL_A_MASK = 8'hF3;
	localparam int unsigned C_FORCE_A_BIT = 7;
	localparam int unsigned C_FORCE_B_BIT = 6;
	localparam int unsigned F_CAPTURE_BIT = 5;
	localparam int unsigned F_COMPARE_A_BIT = 1;
	localparam int unsigned O_SRC_CMP_BIT = 0;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_WORD = 16'h0000;

	// ************************************************************
	// clock select, prescaler, filter
	// ************************************************************
	typedef enum logic [2:0] {
		CS_STOP = 3'h0,
		CS_DIV1 = 3'h1,
		CS_DIV8 = 3'h2,
		CS_DIV64 = 3'h3,
		CS_DIV256 = 3'h4,
		CS_DIV1024 = 3'h5,
		CS_EXT_FALL = 3'h6,
		CS_EXT_RISE = 3'h7
	} tcc_clk_sel_t;
	localparam int unsigned PRESCALE_W = 10;
	localparam logic [9:0] MASK_DIV8 = 10'h007;
	localparam logic [9:0] MASK_DIV64 = 10'h03F;
	localparam logic [9:0] MASK_DIV256 = 10'h0FF;
	localparam logic [9:0] MASK_DIV1024 = 10'h3FF;
	localparam int unsigned FILTER_LEN = 4;

	// ************************************************************
	// wave modes, tops, output actions
	// ************************************************************
	localparam logic [3:0] MODE_NORMAL = 4'h0;
	localparam logic [3:0] MODE_CTC_CMPA = 4'h4;
	localparam logic [3:0] MODE_CTC_CAP = 4'hC;
	localparam logic [15:0] TOP_MAX = 16'hFFFF;
	localparam logic [15:0] TOP_8BIT = 16'h00FF;
	localparam logic [15:0] TOP_9BIT = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;

	// capture front-end settings
	typedef struct packed {
		logic filter_en;
		logic rising;
	} tcc_cap_cfg_t;

endpackage : tcc_pkg

// >>> design/tcc_capture_filter.sv
// ************************************************************
// capture front end: sampling, noise filter, edge detect
// ************************************************************
module tcc_capture_filter (
	input wire logic clk,
	input wire logic rst_n,
	input tcc_pkg::tcc_cap_cfg_t cfg,
	input wire logic sample,
	output logic trigger
);

	typedef struct packed {
		logic raw;
		logic raw_d;
		logic [tcc_pkg::FILTER_LEN-1:0] hist;
		logic filt;
		logic level_prev;
		logic trig;
	} tcc_cap_state_t;

	tcc_cap_state_t st_r;
	tcc_cap_state_t st_nxt;
	logic level;

	// level chosen from delayed raw or filtered copy
	always_comb begin
		level = cfg.filter_en ? st_r.filt : st_r.raw_d;
		st_nxt = st_r;
		st_nxt.raw = sample;
		st_nxt.raw_d = st_r.raw;
		st_nxt.hist = {st_r.hist[tcc_pkg::FILTER_LEN-2:0], st_r.raw};
		// output moves only on a full run of equal samples
		if (&st_r.hist) begin
			st_nxt.filt = 1'b1;
		end else if (~|st_r.hist) begin
			st_nxt.filt = 1'b0;
		end
		st_nxt.level_prev = level;
		// rising when select is one, falling when zero
		st_nxt.trig = cfg.rising ? (level & ~st_r.level_prev)
			: (~level & st_r.level_prev);
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign trigger = st_r.trig;

endmodule : tcc_capture_filter

// >>> design/tcc_timer16.sv
// ************************************************************
// 16-bit timer: clock select, capture, compare A, byte access
// ************************************************************
//
// Implementation choice: strobed register access.
module tcc_timer16 (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WR_DATA,
	input wire logic WR_EN,
	input wire logic RD_EN,
	output logic [7:0] RD_DATA,
	input wire logic CAPTURE_PIN,
	input wire logic EXT_COUNT_PIN,
	input wire logic COMPARATOR_IN,
	input wire logic CAPTURE_VECTOR_ACK,
	output logic WAVE_OUT_A,
	output logic WAVE_OUT_B,
	output logic CAPTURE_FLAG,
	output logic COMPARE_A_FLAG
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic [7:0] ctrl_a;
		logic [7:0] ctrl_b;
		logic [15:0] count;
		logic [15:0] capture;
		logic [15:0] compare_a;
		logic [7:0] temp;
		logic src_cmp;
		logic [tcc_pkg::PRESCALE_W-1:0] prescale;
		logic ext_prev;
		logic block;
		logic cap_flag;
		logic cmpa_flag;
		logic wave_a;
		logic wave_b;
		logic [7:0] rd_data;
	} tcc_state_t;

	tcc_state_t st_r;
	tcc_state_t st_nxt;

	// ************************************************************
	// helpers
	// ************************************************************

	// top value for each wave mode
	function automatic logic [15:0] top_of(input logic [3:0] mode,
		input logic [15:0] cmpa, input logic [15:0] icr);
		logic [15:0] t;
		t = tcc_pkg::TOP_MAX;
		unique case (mode)
			4'h1, 4'h5: t = tcc_pkg::TOP_8BIT;
			4'h2, 4'h6: t = tcc_pkg::TOP_9BIT;
			4'h3, 4'h7: t = tcc_pkg::TOP_10BIT;
			4'h4, 4'h9, 4'hB, 4'hF: t = cmpa;
			4'h8, 4'hA, 4'hC, 4'hE: t = icr;
			default: t = tcc_pkg::TOP_MAX;
		endcase
		return t;
	endfunction : top_of

	// capture register serves as top
	function automatic logic cap_is_top(input logic [3:0] mode);
		return (mode == 4'h8) || (mode == 4'hA) || (mode == 4'hC)
			|| (mode == 4'hE);
	endfunction : cap_is_top

	// normal and clear-on-match modes
	function automatic logic non_pwm(input logic [3:0] mode);
		return (mode == tcc_pkg::MODE_NORMAL) || (mode == tcc_pkg::MODE_CTC_CMPA)
			|| (mode == tcc_pkg::MODE_CTC_CAP);
	endfunction : non_pwm

	// output action on a compare match
	function automatic logic apply_action(input logic [1:0] act, input logic cur);
		logic v;
		v = cur;
		unique case (act)
			tcc_pkg::ACT_NONE: v = cur;
			tcc_pkg::ACT_TOGGLE: v = ~cur;
			tcc_pkg::ACT_CLEAR: v = 1'b0;
			tcc_pkg::ACT_SET: v = 1'b1;
		endcase
		return v;
	endfunction : apply_action

	// ************************************************************
	// capture front end
	// ************************************************************
	tcc_pkg::tcc_cap_cfg_t cap_cfg;
	logic cap_src;
	logic cap_trig;

	// source mux and front-end settings
	always_comb begin
		cap_src = st_r.src_cmp ? COMPARATOR_IN : CAPTURE_PIN;
		cap_cfg.filter_en = st_r.ctrl_b[tcc_pkg::B_NOISE_BIT];
		cap_cfg.rising = st_r.ctrl_b[tcc_pkg::B_EDGE_BIT];
	end

	tcc_capture_filter u_cap (
		.clk(CLOCK),
		.rst_n(RST_N),
		.cfg(cap_cfg),
		.sample(cap_src),
		.trigger(cap_trig)
	);

	// ************************************************************
	// next-state logic
	// ************************************************************
	logic [3:0] mode;
	logic [2:0] cs;
	logic [1:0] act_a;
	logic [1:0] act_b;
	logic tick;
	logic [15:0] top;
	logic match_a;
	logic wr_hi;
	logic wr_lo;
	logic rd_lo;
	logic [15:0] rd_word;

	// decoded fields
	always_comb begin
		mode = {st_r.ctrl_b[tcc_pkg::B_WM3_BIT], st_r.ctrl_b[tcc_pkg::B_WM2_BIT],
			st_r.ctrl_a[tcc_pkg::A_WM_LSB +: 2]};
		cs = st_r.ctrl_b[tcc_pkg::B_CS_LSB +: 3];
		act_a = st_r.ctrl_a[tcc_pkg::A_ACT_A_LSB +: 2];
		act_b = st_r.ctrl_a[tcc_pkg::A_ACT_B_LSB +: 2];
		top = top_of(mode, st_r.compare_a, st_r.capture);
	end

	// timer clock enable from the selected source
	always_comb begin
		tick = 1'b0;
		unique case (tcc_pkg::tcc_clk_sel_t'(cs))
			tcc_pkg::CS_STOP: tick = 1'b0;
			tcc_pkg::CS_DIV1: tick = 1'b1;
			tcc_pkg::CS_DIV8: tick = (st_r.prescale & tcc_pkg::MASK_DIV8)
				== tcc_pkg::MASK_DIV8;
			tcc_pkg::CS_DIV64: tick = (st_r.prescale & tcc_pkg::MASK_DIV64)
				== tcc_pkg::MASK_DIV64;
			tcc_pkg::CS_DIV256: tick = (st_r.prescale & tcc_pkg::MASK_DIV256)
				== tcc_pkg::MASK_DIV256;
			tcc_pkg::CS_DIV1024: tick = st_r.prescale == tcc_pkg::MASK_DIV1024;
			// external pin: edge seen one clock after the pin moves
			tcc_pkg::CS_EXT_FALL: tick = st_r.ext_prev & ~EXT_COUNT_PIN;
			tcc_pkg::CS_EXT_RISE: tick = ~st_r.ext_prev & EXT_COUNT_PIN;
		endcase
	end

	// main update: flags, counter, capture, bus
	always_comb begin
		st_nxt = st_r;
		// free-running prescaler and external pin history
		st_nxt.prescale = st_r.prescale + 1'b1;
		st_nxt.ext_prev = EXT_COUNT_PIN;
		st_nxt.rd_data = tcc_pkg::RESET_BYTE;
		wr_hi = 1'b0;
		wr_lo = 1'b0;
		rd_lo = 1'b0;
		rd_word = tcc_pkg::RESET_WORD;
		// a counter write holds off the match on the next timer clock
		match_a = tick && (st_r.count == st_r.compare_a) && !st_r.block;

		// flag clears first so a same-cycle set wins
		if (CAPTURE_VECTOR_ACK) begin
			st_nxt.cap_flag = 1'b0;
		end
		// writing a one clears that flag
		if (WR_EN && ADDR == tcc_pkg::OFS_FLAGS) begin
			if (WR_DATA[tcc_pkg::F_CAPTURE_BIT]) begin
				st_nxt.cap_flag = 1'b0;
			end
			if (WR_DATA[tcc_pkg::F_COMPARE_A_BIT]) begin
				st_nxt.cmpa_flag = 1'b0;
			end
		end

		// counting and compare match on the timer clock
		if (tick) begin
			st_nxt.block = 1'b0;
			st_nxt.count = (st_r.count == top) ? tcc_pkg::RESET_WORD
				: st_r.count + 16'h0001;
			if (match_a) begin
				st_nxt.cmpa_flag = 1'b1;
				st_nxt.wave_a = apply_action(act_a, st_r.wave_a);
			end
			// capture register as top: flag marks reaching top
			if (cap_is_top(mode) && st_r.count == top) begin
				st_nxt.cap_flag = 1'b1;
			end
		end

		// capture event, unless capture register is top
		if (cap_trig && !cap_is_top(mode)) begin
			st_nxt.capture = st_r.count;
			st_nxt.cap_flag = 1'b1;
		end

		// register writes; 16-bit registers go through the shared holding byte
		if (WR_EN) begin
			unique case (ADDR)
				tcc_pkg::OFS_CTRL_A: st_nxt.ctrl_a = WR_DATA & tcc_pkg::CTRL_A_MASK;
				tcc_pkg::OFS_CTRL_B: st_nxt.ctrl_b = WR_DATA & tcc_pkg::CTRL_B_MASK;
				tcc_pkg::OFS_CTRL_C: begin
					// force strobes: output action only, no flag, no clear
					if (non_pwm(mode)) begin
						if (WR_DATA[tcc_pkg::C_FORCE_A_BIT]) begin
							st_nxt.wave_a = apply_action(act_a, st_nxt.wave_a);
						end
						if (WR_DATA[tcc_pkg::C_FORCE_B_BIT]) begin
							st_nxt.wave_b = apply_action(act_b, st_r.wave_b);
						end
					end
				end
				tcc_pkg::OFS_OPTION: st_nxt.src_cmp = WR_DATA[tcc_pkg::O_SRC_CMP_BIT];
				tcc_pkg::OFS_COUNT + tcc_pkg::HIGH_BYTE_STEP,
				tcc_pkg::OFS_CAPTURE + tcc_pkg::HIGH_BYTE_STEP,
				tcc_pkg::OFS_COMPARE_A + tcc_pkg::HIGH_BYTE_STEP: wr_hi = 1'b1;
				tcc_pkg::OFS_COUNT, tcc_pkg::OFS_CAPTURE,
				tcc_pkg::OFS_COMPARE_A: wr_lo = 1'b1;
				default: wr_hi = 1'b0;
			endcase
		end
		// high-byte writes only park data in the holding byte
		if (wr_hi) begin
			st_nxt.temp = WR_DATA;
		end
		if (wr_lo) begin
			// low byte commits both bytes together
			unique case (ADDR)
				tcc_pkg::OFS_COUNT: begin
					st_nxt.count = {st_r.temp, WR_DATA};
					st_nxt.block = 1'b1;
				end
				tcc_pkg::OFS_CAPTURE: st_nxt.capture = {st_r.temp, WR_DATA};
				default: st_nxt.compare_a = {st_r.temp, WR_DATA};
			endcase
		end

		// reads: data stand one cycle later
		if (RD_EN) begin
			unique case (ADDR)
				tcc_pkg::OFS_CTRL_A: st_nxt.rd_data = st_r.ctrl_a;
				tcc_pkg::OFS_CTRL_B: st_nxt.rd_data = st_r.ctrl_b;
				tcc_pkg::OFS_CTRL_C: st_nxt.rd_data = tcc_pkg::RESET_BYTE;
				tcc_pkg::OFS_OPTION: st_nxt.rd_data = {7'h00, st_r.src_cmp};
				tcc_pkg::OFS_FLAGS: begin
					st_nxt.rd_data[tcc_pkg::F_CAPTURE_BIT] = st_r.cap_flag;
					st_nxt.rd_data[tcc_pkg::F_COMPARE_A_BIT] = st_r.cmpa_flag;
				end
				tcc_pkg::OFS_COUNT + tcc_pkg::HIGH_BYTE_STEP,
				tcc_pkg::OFS_CAPTURE + tcc_pkg::HIGH_BYTE_STEP,
				tcc_pkg::OFS_COMPARE_A + tcc_pkg::HIGH_BYTE_STEP:
					st_nxt.rd_data = st_r.temp;
				tcc_pkg::OFS_COUNT: begin
					rd_lo = 1'b1;
					rd_word = st_r.count;
				end
				tcc_pkg::OFS_CAPTURE: begin
					rd_lo = 1'b1;
					rd_word = st_r.capture;
				end
				tcc_pkg::OFS_COMPARE_A: begin
					rd_lo = 1'b1;
					rd_word = st_r.compare_a;
				end
				default: st_nxt.rd_data = tcc_pkg::RESET_BYTE;
			endcase
		end
		// low-byte read returns the low byte and parks the high byte
		if (rd_lo) begin
			st_nxt.rd_data = rd_word[7:0];
			st_nxt.temp = rd_word[15:8];
		end
	end

	// ************************************************************
	// state register and outputs
	// ************************************************************

	// synchronous reset to all zero
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state flops
	assign RD_DATA = st_r.rd_data;
	assign WAVE_OUT_A = st_r.wave_a;
	assign WAVE_OUT_B = st_r.wave_b;
	assign CAPTURE_FLAG = st_r.cap_flag;
	assign COMPARE_A_FLAG = st_r.cmpa_flag;

endmodule : tcc_timer16

// >>> bench/tcc_pin_model.sv
// ****************************************
// capture and count pins driven from outside
// ****************************************
module tcc_pin_model (
	input wire logic clk,
	input wire logic cap_lvl,
	input wire logic go,
	input wire logic [7:0] n,
	output logic cap_pin,
	output logic ext_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic c_r = 1'b0;
	logic e_r = 1'b0;
	logic [8:0] rem_r = 9'h000;
	logic [1:0] div_r = 2'h0;
	assign cap_pin = c_r;
	assign ext_pin = e_r;
	// capture level follows request; count pin gives n slow pulses, idles low
	always @(posedge clk) begin
		c_r <= cap_lvl;
		div_r <= div_r + 2'h1;
		if (go) begin
			rem_r <= {n, 1'b0};
		end else if (div_r == 2'h3 && rem_r != 9'h000) begin
			e_r <= !e_r;
			rem_r <= rem_r - 9'h001;
		end
	end
endmodule : tcc_pin_model

// >>> bench/tcc_timer16_chk.sv
// ****************************************
// port checker
// ****************************************
module tcc_timer16_chk (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WR_DATA,
	input wire logic WR_EN,
	input wire logic RD_EN,
	input wire logic [7:0] RD_DATA,
	input wire logic CAPTURE_PIN,
	input wire logic CAPTURE_VECTOR_ACK,
	input wire logic WAVE_OUT_B,
	input wire logic CAPTURE_FLAG,
	input wire logic COMPARE_A_FLAG
);
	logic [7:0] a_r;
	logic [7:0] b_r;
	logic o_r;
	logic ok;
	// shadow of control bytes written by software
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			a_r <= 8'h00;
			b_r <= 8'h00;
			o_r <= 1'b0;
		end else if (WR_EN) begin
			if (ADDR == 8'h80) a_r <= WR_DATA;
			if (ADDR == 8'h81) b_r <= WR_DATA;
			if (ADDR == 8'h8D) o_r <= WR_DATA[0];
		end
	end
	// pin is the source and capture is not the top
	assign ok = !o_r && !(b_r[4] && !a_r[0]);
	default clocking dc @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	property p_rd_idle;
		!$past(RD_EN) |-> RD_DATA == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_rd_force;
		RD_EN && ADDR == 8'h82 |=> RD_DATA == 8'h00;
	endproperty
	a_rd_force: assert property (p_rd_force) else $error("force byte read");
	property p_rd_hole;
		RD_EN && ADDR == 8'h83 |=> RD_DATA == 8'h00;
	endproperty
	a_rd_hole: assert property (p_rd_hole) else $error("hole read");
	property p_rd_flags;
		RD_EN && ADDR == 8'h8C |=> (RD_DATA & 8'hDD) == 8'h00;
	endproperty
	a_rd_flags: assert property (p_rd_flags) else $error("flag spare bits");
	property p_force_b;
		$changed(WAVE_OUT_B) |-> $past(WR_EN && ADDR == 8'h82 && WR_DATA[6]);
	endproperty
	a_force_b: assert property (p_force_b) else $error("out b moved");
	property p_force_flag;
		$rose(COMPARE_A_FLAG) |-> !$past(WR_EN && ADDR == 8'h82);
	endproperty
	a_force_flag: assert property (p_force_flag) else $error("force set flag");
	property p_cap_clr;
		$fell(CAPTURE_FLAG) |-> $past(CAPTURE_VECTOR_ACK || (WR_EN && ADDR == 8'h8C && WR_DATA[5]));
	endproperty
	a_cap_clr: assert property (p_cap_clr) else $error("capture flag lost");
	property p_cap_raw;
		ok && b_r[6] && !b_r[7] && $rose(CAPTURE_PIN) |-> ##4 CAPTURE_FLAG;
	endproperty
	a_cap_raw: assert property (p_cap_raw) else $error("raw capture late");
	property p_cap_filt;
		ok && b_r[6] && b_r[7] && $rose(CAPTURE_PIN) ##1 CAPTURE_PIN [*3] |-> ##5 CAPTURE_FLAG;
	endproperty
	a_cap_filt: assert property (p_cap_filt) else $error("filtered capture late");
endmodule : tcc_timer16_chk

bind tcc_timer16 tcc_timer16_chk i_chk (
	.CLOCK(CLOCK),
	.RST_N(RST_N),
	.ADDR(ADDR),
	.WR_DATA(WR_DATA),
	.WR_EN(WR_EN),
	.RD_EN(RD_EN),
	.RD_DATA(RD_DATA),
	.CAPTURE_PIN(CAPTURE_PIN),
	.CAPTURE_VECTOR_ACK(CAPTURE_VECTOR_ACK),
	.WAVE_OUT_B(WAVE_OUT_B),
	.CAPTURE_FLAG(CAPTURE_FLAG),
	.COMPARE_A_FLAG(COMPARE_A_FLAG)
);

// >>> bench/tb.sv
// ****************************************
// timer testbench
// ****************************************
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic cmp_in = 1'b0;
	logic ack = 1'b0;
	logic cap_lvl = 1'b0;
	logic go = 1'b0;
	logic [7:0] n = 8'h00;
	logic [7:0] rd_data;
	logic cap_pin, ext_pin, wave_a, wave_b, cap_flag, cmp_flag;
	int error_cnt = 0;
	int comparisons = 0;
	always #10 clock = !clock;
	tcc_timer16 i_dut (.CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WR_DATA(wr_data),
		.WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data), .CAPTURE_PIN(cap_pin),
		.EXT_COUNT_PIN(ext_pin), .COMPARATOR_IN(cmp_in), .CAPTURE_VECTOR_ACK(ack),
		.WAVE_OUT_A(wave_a), .WAVE_OUT_B(wave_b), .CAPTURE_FLAG(cap_flag),
		.COMPARE_A_FLAG(cmp_flag));
	tcc_pin_model i_pins (.clk(clock), .cap_lvl(cap_lvl), .go(go), .n(n),
		.cap_pin(cap_pin), .ext_pin(ext_pin));
	task automatic conclude();
		$display("errors %0d of %0d compares", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic chk_rng(input logic [15:0] g, input int lo, input int hi);
		comparisons++;
		if ((g >= lo && g <= hi) !== 1'b1) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, lo);
		end
	endtask : chk_rng
	task automatic idle(input int k);
		repeat (k) @(posedge clock);
	endtask : idle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask : rd
	// high byte first on write, low byte first on read
	task automatic w16(input logic [7:0] a, input logic [15:0] v);
		wr(a + 8'h01, v[15:8]);
		wr(a, v[7:0]);
	endtask : w16
	task automatic r16(input logic [7:0] a, output logic [15:0] v);
		rd(a, v[7:0]);
		rd(a + 8'h01, v[15:8]);
	endtask : r16
	task automatic wait_flag(input logic sel);
		for (int i = 0; i < 3000; i++) begin
			@(posedge clock);
			#1;
			if ((sel ? cmp_flag : cap_flag) === 1'b1) return;
		end
		error_cnt++;
		conclude();
	endtask : wait_flag
	// reset values, spare bits, shared high byte
	task automatic t_regs();
		logic [7:0] d;
		logic [15:0] v;
		for (int a = 8'h80; a <= 8'h8D; a++) begin
			rd(a[7:0], d);
			chk(d, 8'h00);
		end
		wr(8'h81, 8'hF8);
		rd(8'h81, d);
		chk(d, 8'hD8);
		wr(8'h81, 8'h00);
		w16(8'h88, 16'hA55A);
		r16(8'h88, v);
		chk(v, 16'hA55A);
		wr(8'h89, 8'h77);
		wr(8'h86, 8'h01);
		r16(8'h86, v);
		chk(v, 16'h7701);
	endtask : t_regs
	// every clock select code over a fixed span
	task automatic t_clk();
		int dv[8] = '{0, 1, 8, 64, 256, 1024, 0, 0};
		logic [15:0] v;
		int e;
		for (int k = 0; k < 8; k++) begin
			w16(8'h84, 16'h0000);
			wr(8'h81, k[7:0]);
			n <= 8'h05;
			go <= (k > 5);
			idle(1);
			go <= 1'b0;
			idle(2048);
			wr(8'h81, 8'h00);
			r16(8'h84, v);
			e = (k > 5) ? 5 : (k == 0) ? 0 : 2048 / dv[k];
			chk_rng(v, e, e + ((k > 5 || k == 0) ? 0 : 3));
		end
	endtask : t_clk
	task automatic cap_once(input logic [7:0] cfg, output logic [15:0] v);
		wr(8'h81, cfg & 8'hF8);
		w16(8'h84, 16'h0000);
		wr(8'h81, cfg);
		cap_lvl <= 1'b1;
		wait_flag(1'b0);
		r16(8'h86, v);
		wr(8'h8C, 8'h20);
		cap_lvl <= 1'b0;
		idle(12);
		#1 chk(cap_flag, 1'b0);
	endtask : cap_once
	// filter delay, glitch, capture as top, comparator source
	task automatic t_cap();
		logic [15:0] v0, v1;
		cap_once(8'h41, v0);
		cap_once(8'hC1, v1);
		chk(v1 - v0, 16'h0004);
		idle(1);
		cap_lvl <= 1'b1;
		idle(2);
		cap_lvl <= 1'b0;
		idle(12);
		#1 chk(cap_flag, 1'b0);
		wr(8'h81, 8'h58);
		cap_lvl <= 1'b1;
		idle(12);
		#1 chk(cap_flag, 1'b0);
		wr(8'h81, 8'h41);
		cap_lvl <= 1'b0;
		wr(8'h8D, 8'h01);
		cmp_in <= 1'b1;
		wait_flag(1'b0);
		@(posedge clock);
		ack <= 1'b1;
		@(posedge clock);
		ack <= 1'b0;
		idle(1);
		#1 chk(cap_flag, 1'b0);
		wr(8'h8D, 8'h00);
		cmp_in <= 1'b0;
		// falling edge selected: rise ignored, fall captures
		idle(4);
		wr(8'h81, 8'h01);
		cap_lvl <= 1'b1;
		idle(12);
		#1 chk(cap_flag, 1'b0);
		cap_lvl <= 1'b0;
		wait_flag(1'b0);
		wr(8'h8C, 8'h20);
		// capture register as top: flag on reaching top, counter wraps
		wr(8'h81, 8'h00);
		w16(8'h86, 16'h0020);
		w16(8'h84, 16'h0000);
		wr(8'h81, 8'h19);
		wait_flag(1'b0);
		wr(8'h81, 8'h00);
		r16(8'h84, v0);
		chk_rng(v0, 1, 3);
		wr(8'h8C, 8'h20);
	endtask : t_cap
	// compare match, blocked match, forced strobes
	task automatic t_cmp();
		logic [15:0] v;
		wr(8'h80, 8'h40);
		w16(8'h88, 16'h0010);
		w16(8'h84, 16'h0000);
		wr(8'h81, 8'h01);
		wait_flag(1'b1);
		chk(wave_a, 1'b1);
		wr(8'h81, 8'h00);
		wr(8'h8C, 8'h02);
		w16(8'h88, 16'h0005);
		w16(8'h84, 16'h0005);
		wr(8'h81, 8'h01);
		idle(20);
		#1 chk(cmp_flag, 1'b0);
		wr(8'h81, 8'h08);
		wr(8'h80, 8'h74);
		w16(8'h84, 16'h0033);
		wr(8'h82, 8'hC0);
		#1 chk({wave_a, wave_b, cmp_flag}, 3'b010);
		r16(8'h84, v);
		chk(v, 16'h0033);
		wr(8'h81, 8'h00);
		wr(8'h80, 8'h61);
		wr(8'h82, 8'hC0);
		#1 chk({wave_a, wave_b}, 2'b01);
	endtask : t_cmp
	initial begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		t_regs();
		t_clk();
		t_cap();
		t_cmp();
		conclude();
	end
endmodule : tb
